// file: logic/sysctl_consts.svh
// constants for the system control coprocessor register set
`ifndef SYSCTL_CONSTS_SVH
`define SYSCTL_CONSTS_SVH
// register numbers as carried in the coprocessor register field
`define CRN_IDENT 4'h0
`define CRN_CTRL 4'h1
`define CRN_TABLE_BASE 4'h2
`define CRN_DOMAIN 4'h3
`define CRN_RSVD4 4'h4
`define CRN_FAULT_STATUS 4'h5
`define CRN_FAULT_ADDR 4'h6
// secondary opcode selects inside register 0
`define OP2_IDENT 3'h0
`define OP2_CACHE 3'h1
// control register bit positions
`define CTRL_MMU 0
`define CTRL_ALIGN 1
`define CTRL_DCACHE 2
`define CTRL_ENDIAN 7
`define CTRL_SYSPROT 8
`define CTRL_ROMPROT 9
`define CTRL_ICACHE 12
`define CTRL_VECTOR 13
`define CTRL_RROBIN 14
`define CTRL_CLK_LO 30
`define CTRL_CLK_HI 31
// writable control bits, bits that always read one, reset value
`define CTRL_WMASK 32'hc000_7387
`define CTRL_FIXED 32'h0000_0078
`define CTRL_RESET 32'h0000_0000
// reset values of the other stored registers
`define TABLE_BASE_RESET 18'h0
`define DOMAIN_RESET 32'h0
`define FAULT_STATUS_RESET 8'h0
`define FAULT_ADDR_RESET 32'h0
`define READ_DATA_RESET 32'h0
// exception vector bases
`define VEC_LOW 32'h0000_0000
`define VEC_HIGH 32'hffff_0000
// table base pointer lies in 31:14
`define TABLE_BASE_LSB 14
// cache type word layout
`define CT_SEPARATE 24
`define CT_DGEO_LSB 12
`define CT_TYPE_LSB 25
// fault status layout
`define FAULT_DOM_LSB 4
`endif

// file: logic/sysctl_pkg.sv
// types shared by the system control coprocessor register set
package sysctl_pkg;
    typedef enum logic [1:0] {
        clk_fast_bus = 2'h0,
        clk_sync = 2'h1,
        clk_reserved = 2'h2,
        clk_async = 2'h3
    } clock_mode_type;
    typedef enum logic [1:0] {
        dom_no_access = 2'h0,
        dom_client = 2'h1,
        dom_reserved = 2'h2,
        dom_manager = 2'h3
    } domain_access_type;
    typedef struct packed {
        logic valid;
        logic read;
        logic [3:0] crn;
        logic [2:0] op2;
        logic [31:0] wdata;
    } cp_req_type;
    typedef struct packed {
        logic data_valid;
        logic prefetch_valid;
        logic [3:0] status;
        logic [3:0] domain;
        logic [31:0] addr;
    } abort_type;
    typedef struct packed {
        logic mmu_en;
        logic align_en;
        logic dcache_en;
        logic big_endian;
        logic sys_prot;
        logic rom_prot;
        logic icache_en;
        logic roundrobin_select;
        clock_mode_type clock_mode;
        logic [31:0] vector_base;
        logic [17:0] table_base_pointer;
    } ctrl_out_type;
endpackage

// file: logic/system_control_coproc_regs.sv
// system control coprocessor register bank of the processor core
// Function
// - id word: architecture, variant, implementor fields
// - register 0, opcode 1 reads cache type
// - cache type bit 24 reads one
// - cache type carries geometries and type code
// - control bit 1 enables alignment checking
// - control bit 7 selects big endian
// - control bit 13 selects high vectors
// - control bit 14 selects round robin
// - control bits 31:30 select clocking mode
// - control bits 8, 9 protection modifiers held
// - table base holds pointer in 31:14
// - undefined bits written zero, read anything
// - sixteen two-bit domain fields, domain 0 lowest
// - domain field: none, client, reserved, manager
// - data abort records type and domain
// - fault status write loads written data
// - fault address captured on data faults only
// - fault address write loads, read returns
// - register 0 opcode 0 reads id word
// - reset invalidates and disables instruction cache
`timescale 1ns/1ps
`include "sysctl_consts.svh"

module system_control_coproc_regs #(
    parameter logic [7:0] IMPLEMENTOR = 8'h5a, // arbitrary value
    parameter logic [3:0] VARIANT = 4'h7, // arbitrary value
    parameter logic [3:0] ARCH_CODE = 4'h3, // arbitrary value
    parameter logic [11:0] PART_NUMBER = 12'h123, // arbitrary value
    parameter logic [3:0] LAYOUT_REV = 4'h0, // arbitrary value
    parameter logic [11:0] INSTR_CACHE_GEOMETRY = 12'h000,
    parameter logic [11:0] DATA_CACHE_GEOMETRY = 12'h000,
    parameter logic [3:0] CACHE_TYPE_CODE = 4'h0,
    parameter int DOMAINS = 16
) (
    input wire logic mclk, // 200 MHz core clock
    input wire logic srst, // synchronous reset, active high
    input wire sysctl_pkg::cp_req_type cp_req, // coprocessor transfer
    input wire sysctl_pkg::abort_type abort_in, // abort report from mmu
    input wire logic [3:0] domain_query, // domain to look up
    output sysctl_pkg::domain_access_type domain_access, // its access kind
    output logic [31:0] cp_rdata, // read data
    output logic cp_rvalid, // read data valid pulse
    output sysctl_pkg::ctrl_out_type ctrl_out, // decoded controls
    output logic icache_invalidate // invalidate all instr lines
);

    ////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (DOMAINS * 2 != 32)
    begin : g_dom_check
        $error("domain count must fill one 32-bit word");
    end

    ////////////////////////////////////////////////////////////////////
    // helpers

    // picks one two-bit domain field, domain 0 in the low bits
    function automatic sysctl_pkg::domain_access_type dom_field(
        input logic [31:0] dacr,
        input logic [3:0] idx
    );
        dom_field = sysctl_pkg::domain_access_type'(dacr[{idx, 1'b0} +: 2]);
    endfunction

    // true when the request writes the given register
    function automatic logic is_write(input sysctl_pkg::cp_req_type r, input logic [3:0] n);
        is_write = r.valid && !r.read && (r.crn == n);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [17:0] table_base_q;
    logic [17:0] table_base_d;
    logic [31:0] dacr_q;
    logic [31:0] dacr_d;
    logic [7:0] fault_status_q;
    logic [7:0] fault_status_d;
    logic [31:0] fault_address_q;
    logic [31:0] fault_address_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic inval_q;
    logic inval_d;
    logic [31:0] ident_word;
    logic [31:0] cache_word;

    // fixed words of register 0
    assign ident_word = {IMPLEMENTOR, VARIANT, ARCH_CODE, PART_NUMBER, LAYOUT_REV};
    assign cache_word = {3'h0, CACHE_TYPE_CODE, 1'b1, DATA_CACHE_GEOMETRY,
                         INSTR_CACHE_GEOMETRY};

    ////////////////////////////////////////////////////////////////////
    // register writes and hardware capture

    // a data abort beats a software write in the same cycle so no fault is lost
    always_comb
    begin
        ctrl_d = ctrl_q;
        table_base_d = table_base_q;
        dacr_d = dacr_q;
        fault_status_d = fault_status_q;
        fault_address_d = fault_address_q;
        inval_d = 1'b0;
        // undefined control bits are never stored
        if (is_write(cp_req, `CRN_CTRL))
            ctrl_d = cp_req.wdata & `CTRL_WMASK;
        if (is_write(cp_req, `CRN_TABLE_BASE))
            table_base_d = cp_req.wdata[31:`TABLE_BASE_LSB];
        if (is_write(cp_req, `CRN_DOMAIN))
            dacr_d = cp_req.wdata;
        if (is_write(cp_req, `CRN_FAULT_STATUS))
            fault_status_d = cp_req.wdata[7:0];
        if (is_write(cp_req, `CRN_FAULT_ADDR))
            fault_address_d = cp_req.wdata;
        // prefetch faults leave both fault registers alone
        if (abort_in.data_valid)
        begin
            fault_status_d = {abort_in.domain, abort_in.status};
            fault_address_d = abort_in.addr;
        end
    end

    // register 0 and register 4 writes fall through with no effect
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_q <= `CTRL_RESET;
            table_base_q <= `TABLE_BASE_RESET;
            dacr_q <= `DOMAIN_RESET;
            fault_status_q <= `FAULT_STATUS_RESET;
            fault_address_q <= `FAULT_ADDR_RESET;
            inval_q <= 1'b1;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            table_base_q <= table_base_d;
            dacr_q <= dacr_d;
            fault_status_q <= fault_status_d;
            fault_address_q <= fault_address_d;
            inval_q <= inval_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path

    // one cycle read latency; register 4 and unmapped numbers read zero
    always_comb
    begin
        rvalid_d = cp_req.valid && cp_req.read;
        rdata_d = rdata_q;
        if (cp_req.valid && cp_req.read)
        begin
            case (cp_req.crn)
                `CRN_IDENT:
                    rdata_d = (cp_req.op2 == `OP2_CACHE) ? cache_word : ident_word;
                `CRN_CTRL:
                    rdata_d = (ctrl_q & `CTRL_WMASK) | `CTRL_FIXED;
                `CRN_TABLE_BASE:
                    rdata_d = {table_base_q, 14'h0};
                `CRN_DOMAIN:
                    rdata_d = dacr_q;
                `CRN_FAULT_STATUS:
                    rdata_d = {24'h0, fault_status_q};
                `CRN_FAULT_ADDR:
                    rdata_d = fault_address_q;
                default:
                    rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rdata_q <= `READ_DATA_RESET;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign cp_rdata = rdata_q;
    assign cp_rvalid = rvalid_q;
    assign icache_invalidate = inval_q;
    assign domain_access = dom_field(dacr_q, domain_query);

    // decoded control fields for the mmu, caches and bus interface
    always_comb
    begin
        ctrl_out.mmu_en = ctrl_q[`CTRL_MMU];
        ctrl_out.align_en = ctrl_q[`CTRL_ALIGN];
        ctrl_out.dcache_en = ctrl_q[`CTRL_DCACHE];
        ctrl_out.big_endian = ctrl_q[`CTRL_ENDIAN];
        ctrl_out.sys_prot = ctrl_q[`CTRL_SYSPROT];
        ctrl_out.rom_prot = ctrl_q[`CTRL_ROMPROT];
        ctrl_out.icache_en = ctrl_q[`CTRL_ICACHE];
        ctrl_out.roundrobin_select = ctrl_q[`CTRL_RROBIN];
        ctrl_out.clock_mode = sysctl_pkg::clock_mode_type'(
            ctrl_q[`CTRL_CLK_HI:`CTRL_CLK_LO]);
        ctrl_out.vector_base = ctrl_q[`CTRL_VECTOR] ? `VEC_HIGH : `VEC_LOW;
        ctrl_out.table_base_pointer = table_base_q;
    end

    ////////////////////////////////////////////////////////////////////
    // assertions

    a_read_answers: assert property (@(posedge mclk) disable iff (srst)
        cp_req.valid && cp_req.read && cp_req.crn == `CRN_IDENT
        && cp_req.op2 == `OP2_IDENT |=> cp_rvalid && cp_rdata[31:24] == IMPLEMENTOR
        && cp_rdata[23:20] == VARIANT && cp_rdata[19:16] == ARCH_CODE)
        else $error("id word read wrong");

    a_cache_word: assert property (@(posedge mclk) disable iff (srst)
        cp_req.valid && cp_req.read && cp_req.crn == `CRN_IDENT
        && cp_req.op2 == `OP2_CACHE |=> cp_rvalid && cp_rdata[24]
        && cp_rdata[31:29] == 3'h0 && cp_rdata[11:0] == INSTR_CACHE_GEOMETRY)
        else $error("cache type word read wrong");

    a_table_roundtrip: assert property (@(posedge mclk) disable iff (srst)
        is_write(cp_req, `CRN_TABLE_BASE) ##1 (cp_req.valid && cp_req.read
        && cp_req.crn == `CRN_TABLE_BASE)
        |=> cp_rdata == {$past(cp_req.wdata[31:14], 2), 14'h0})
        else $error("table base read does not match write");

    a_pointer_out: assert property (@(posedge mclk) disable iff (srst)
        is_write(cp_req, `CRN_TABLE_BASE)
        |=> ctrl_out.table_base_pointer == $past(cp_req.wdata[31:14]))
        else $error("table pointer output not following write");

    a_ctrl_enables: assert property (@(posedge mclk) disable iff (srst)
        is_write(cp_req, `CRN_CTRL) |=> ctrl_out.mmu_en == $past(cp_req.wdata[0])
        && ctrl_out.align_en == $past(cp_req.wdata[1])
        && ctrl_out.dcache_en == $past(cp_req.wdata[2])
        && ctrl_out.icache_en == $past(cp_req.wdata[12]))
        else $error("enable bits not following control write");

    a_clock_mode: assert property (@(posedge mclk) disable iff (srst)
        is_write(cp_req, `CRN_CTRL)
        |=> ctrl_out.clock_mode == $past(cp_req.wdata[31:30]))
        else $error("clocking mode not following control write");

    a_vector_base: assert property (@(posedge mclk) disable iff (srst)
        is_write(cp_req, `CRN_CTRL) |=> ctrl_out.vector_base
        == ($past(cp_req.wdata[`CTRL_VECTOR]) ? 32'hffff_0000 : 32'h0000_0000))
        else $error("vector base not following control bit");

    a_fault_capture: assert property (@(posedge mclk) disable iff (srst)
        abort_in.data_valid |=> fault_status_q[7:4] == $past(abort_in.domain)
        && fault_status_q[3:0] == $past(abort_in.status)
        && fault_address_q == $past(abort_in.addr))
        else $error("data abort not recorded");

    a_prefetch_ignored: assert property (@(posedge mclk) disable iff (srst)
        abort_in.prefetch_valid && !abort_in.data_valid
        && !is_write(cp_req, `CRN_FAULT_ADDR) |=> $stable(fault_address_q))
        else $error("fault address changed on prefetch fault");

    a_status_restore: assert property (@(posedge mclk) disable iff (srst)
        is_write(cp_req, `CRN_FAULT_STATUS) && !abort_in.data_valid ##1 (cp_req.valid
        && cp_req.read && cp_req.crn == `CRN_FAULT_STATUS)
        |=> cp_rdata[7:0] == $past(cp_req.wdata[7:0], 2))
        else $error("fault status restore failed");

    a_address_restore: assert property (@(posedge mclk) disable iff (srst)
        is_write(cp_req, `CRN_FAULT_ADDR) && !abort_in.data_valid
        |=> fault_address_q == $past(cp_req.wdata))
        else $error("fault address restore failed");

    a_status_upper: assert property (@(posedge mclk) disable iff (srst)
        cp_req.valid && cp_req.read && cp_req.crn == `CRN_FAULT_STATUS
        |=> cp_rdata[31:8] == 24'h0)
        else $error("fault status upper bits not zero");

    a_read_pulse: assert property (@(posedge mclk) disable iff (srst)
        !(cp_req.valid && cp_req.read) |=> !cp_rvalid)
        else $error("read valid without a read");

    a_reset_state: assert property (@(posedge mclk)
        $fell(srst) |-> icache_invalidate && !ctrl_out.icache_en && !ctrl_out.mmu_en
        && !ctrl_out.dcache_en && ctrl_out.vector_base == 32'h0 ##1 !icache_invalidate)
        else $error("reset state wrong");

    a_domain_lookup: assert property (@(posedge mclk) disable iff (srst)
        is_write(cp_req, `CRN_DOMAIN) |=> domain_access
        == sysctl_pkg::domain_access_type'(2'($past(cp_req.wdata) >> {domain_query, 1'b0})))
        else $error("domain lookup wrong");

endmodule

// file: verif/core_issuer_model.sv
// model of the core issuing coprocessor transfers and abort reports
`timescale 1ns/1ps
module core_issuer_model (
    input wire logic mclk, // core clock
    output sysctl_pkg::cp_req_type cp_req, // transfer to the register bank
    output sysctl_pkg::abort_type abort_in // abort report from the mmu
);
    // quiet bus at time zero
    initial
    begin
        cp_req = '0;
        abort_in = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // entered just after an edge; request held up to the taking edge
    // valid stays up so back to back transfers never toggle it twice
    task automatic xfer(input logic rd, input logic [3:0] crn, input logic [2:0] op2,
                        input logic [31:0] wd);
    begin
        cp_req = '{valid: 1'b1, read: rd, crn: crn, op2: op2, wdata: wd};
        @(posedge mclk);
        #1;
    end
    endtask
    // release; stale write data is inverted so nothing reuses it
    task automatic idle;
    begin
        cp_req.valid = 1'b0;
        cp_req.wdata = ~cp_req.wdata;
        @(posedge mclk);
        #1;
    end
    endtask
    // one-cycle abort pulse, data or prefetch
    task automatic hit(input logic data, input logic [3:0] st, input logic [3:0] dom,
                       input logic [31:0] a);
    begin
        abort_in = '{data_valid: data, prefetch_valid: !data, status: st, domain: dom,
                     addr: a};
        @(posedge mclk);
        #1;
        abort_in = '{data_valid: 1'b0, prefetch_valid: 1'b0, status: ~st, domain: ~dom,
                     addr: ~a};
    end
    endtask
endmodule

// file: verif/system_control_coproc_regs_bench.sv
// self-checking bench for the system control coprocessor register bank
`timescale 1ns/1ps
module system_control_coproc_regs_bench;
    localparam logic [11:0] IGEO = 12'h0a5;
    localparam logic [11:0] DGEO = 12'h3c6;
    localparam logic [3:0] CTYPE = 4'h6;
    logic mclk;
    logic srst;
    logic [3:0] domain_query;
    sysctl_pkg::cp_req_type cp_req;
    sysctl_pkg::abort_type abort_in;
    sysctl_pkg::domain_access_type domain_access;
    logic [31:0] cp_rdata;
    logic cp_rvalid;
    sysctl_pkg::ctrl_out_type ctrl_out;
    logic icache_invalidate;
    int error_cnt;
    int comparisons;
    typedef struct {logic [3:0] crn; logic [31:0] wd; logic [31:0] rd;} row_type;
    row_type rows[7] = '{'{4'h1, 32'hc000_7387, 32'hc000_73ff},
                         '{4'h1, 32'h0000_0000, 32'h0000_0078},
                         '{4'h2, 32'hffff_c000, 32'hffff_c000},
                         '{4'h2, 32'h0001_4000, 32'h0001_4000},
                         '{4'h3, 32'he4e4_1b1b, 32'he4e4_1b1b},
                         '{4'h5, 32'h0000_00a5, 32'h0000_00a5},
                         '{4'h6, 32'h1234_5678, 32'h1234_5678}};
    int pos[9] = '{0, 1, 2, 7, 8, 9, 12, 13, 14};
    ////////////////////////////////////////////////////////////////////////////
    core_issuer_model core (.mclk(mclk), .cp_req(cp_req), .abort_in(abort_in));
    system_control_coproc_regs #(.INSTR_CACHE_GEOMETRY(IGEO), .DATA_CACHE_GEOMETRY(DGEO),
        .CACHE_TYPE_CODE(CTYPE)) dut (.mclk(mclk), .srst(srst), .cp_req(cp_req),
        .abort_in(abort_in), .domain_query(domain_query), .domain_access(domain_access),
        .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid), .ctrl_out(ctrl_out),
        .icache_invalidate(icache_invalidate));
    // 200 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // read answers on the taking edge, one cycle after the request goes up
    task automatic rd(input logic [3:0] crn, input logic [2:0] op2, input logic [31:0] exp);
    begin
        core.xfer(1'b1, crn, op2, 32'h0);
        check(32'(cp_rvalid), 32'h1);
        check(cp_rdata, exp);
    end
    endtask
    task automatic wr(input logic [3:0] crn, input logic [31:0] wd);
    begin
        core.xfer(1'b0, crn, 3'h0, wd);
        core.idle;
    end
    endtask
    task automatic report_and_stop;
    begin
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // a hang counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////////////
    // main sequence: table first, then awkward cases
    initial
    begin
        srst = 1'b1;
        domain_query = 4'h0;
        error_cnt = 0;
        comparisons = 0;
        repeat (16) @(posedge mclk);
        #1;
        check(32'(icache_invalidate), 32'h1);
        check(32'({ctrl_out.mmu_en, ctrl_out.align_en, ctrl_out.dcache_en, ctrl_out.icache_en}),
              32'h0);
        check(ctrl_out.vector_base, 32'h0);
        srst = 1'b0;
        @(posedge mclk);
        #1;
        check(32'(icache_invalidate), 32'h0);
        foreach (rows[i])
        begin
            core.xfer(1'b0, rows[i].crn, 3'h0, rows[i].wd);
            rd(rows[i].crn, 3'h0, rows[i].rd);
            core.idle;
        end
        check(32'(ctrl_out.table_base_pointer), 32'h0000_0005);
        // every domain field through the lookup port
        for (int d = 0; d < 16; d++)
        begin
            domain_query = 4'(d);
            @(posedge mclk);
            #1;
            check(32'(domain_access), (32'he4e4_1b1b >> (2 * d)) & 32'h3);
        end
        // one control bit at a time must move only its own output
        foreach (pos[i])
        begin
            wr(4'h1, 32'h1 << pos[i]);
            check(32'({ctrl_out.roundrobin_select, ctrl_out.vector_base == 32'hffff_0000,
                  ctrl_out.icache_en, ctrl_out.rom_prot, ctrl_out.sys_prot, ctrl_out.big_endian,
                  ctrl_out.dcache_en, ctrl_out.align_en, ctrl_out.mmu_en}), 32'h1 << i);
        end
        wr(4'h1, 32'h0000_2000);
        check(ctrl_out.vector_base, 32'hffff_0000);
        for (int m = 0; m < 4; m++)
        begin
            wr(4'h1, 32'(m) << 30);
            check(32'(ctrl_out.clock_mode), 32'(m));
        end
        // identity then cache type, back to back
        rd(4'h0, 3'h0, 32'h5a73_1230);
        rd(4'h0, 3'h1, {3'h0, CTYPE, 1'b1, DGEO, IGEO});
        core.idle;
        check(32'(cp_rvalid), 32'h0);
        // data abort loads both; prefetch abort leaves the fault address alone
        core.hit(1'b1, 4'h9, 4'hc, 32'hdead_beef);
        rd(4'h5, 3'h0, 32'h0000_00c9);
        rd(4'h6, 3'h0, 32'hdead_beef);
        core.idle;
        core.hit(1'b0, 4'h3, 4'h1, 32'h0bad_f00d);
        rd(4'h6, 3'h0, 32'hdead_beef);
        core.idle;
        // second reset in mid-run
        srst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check(32'(icache_invalidate), 32'h1);
        srst = 1'b0;
        @(posedge mclk);
        #1;
        rd(4'h1, 3'h0, 32'h0000_0078);
        rd(4'h5, 3'h0, 32'h0);
        core.idle;
        report_and_stop;
    end
endmodule
